// File: itps_timing_ctrl.sv
/*
  IDE channel timing control: the primary and secondary timing control
  registers in configuration space, the snooped drive-select copies, and
  the launch of each cable access on its chosen timing path.
  Assumes one access at a time across both channels, configuration
  accesses as single-cycle strobes, and ATA register writes presented on
  the snoop port in the cycle they are issued.
*/
`default_nettype none

// Operation
// - recovery code gives 4,3,2,1 clocks minimum
// - sample-point code gives 5,4,3,2 clocks
// - drive 1 dma-only bit gives fast dma
// - drive 0 dma-only bit gives fast dma
// - dma-only bit keeps pio data compatible
// - drive 1 prefetch/posting bit enables both
// - drive 0 prefetch/posting bit enables both
// - drive 0 sampling off forces ready asserted
// - drive 1 sampling off forces ready asserted
// - sampling on samples ready at programmed point
// - drive 0 bank clear uses 16-bit path
// - drive 1 bank clear uses 16-bit path
// - drive 0 bank set and selected: fast
// - drive 1 bank set and selected: fast
// - drive 1 pio fast only without dma-only
// - drive 0 pio fast only without dma-only
// - non-data ports always use 8-bit path
module itps_timing_ctrl
  import itps_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  // configuration space access, one dword
  input  wire logic                 i_cfg_wr,
  input  wire logic                 i_cfg_rd,
  input  wire logic [7:0]           i_cfg_addr,
  input  wire logic [3:0]           i_cfg_be,
  input  wire logic [31:0]          i_cfg_wdata,
  output logic      [31:0]          o_cfg_rdata,
  output logic                      o_cfg_rvalid,
  // host writes to the ata registers, snooped
  input  wire logic                 i_io_wr,
  input  wire logic                 i_io_chan,
  input  wire logic                 i_io_ctrl_block,
  input  wire logic [2:0]           i_io_offset,
  input  wire logic [7:0]           i_io_wdata,
  // cable access launch
  input  wire logic                 i_acc_start,
  input  wire logic                 i_acc_chan,
  input  wire logic                 i_acc_ctrl_block,
  input  wire logic [2:0]           i_acc_offset,
  input  wire logic                 i_acc_dma,
  input  wire logic                 i_ready,
  output logic                      o_acc_ready,
  output logic                      o_acc_done,
  output itps_pkg::itps_path_e      o_acc_path,
  output logic                      o_acc_prefetch_post,
  output logic                      o_io_strobe,
  // fields handed to the rest of the unit
  output logic      [1:0]           o_decode_enable,
  output logic      [1:0]           o_slave_timing_enable,
  output logic      [1:0]           o_pri_sample_point,
  output logic      [1:0]           o_pri_recovery,
  output logic      [1:0]           o_sec_sample_point,
  output logic      [1:0]           o_sec_recovery,
  output logic      [1:0]           o_drive_select
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0]  timing_pri;
  logic [15:0]  timing_sec;
  logic [15:0]  next_timing_pri;
  logic [15:0]  next_timing_sec;
  logic [31:0]  next_cfg_rdata;
  logic         next_cfg_rvalid;
  logic [1:0]   drive_sel;
  logic [1:0]   next_drive_sel;
  itps_path_e   next_acc_path;
  logic         next_acc_prefetch_post;

  // decode and launch signals
  logic         cfg_hit;
  logic [15:0]  acc_timing;
  logic         acc_drive_sel;
  logic         acc_data_port;
  logic         acc_launch;
  itps_path_e   dec_path;
  logic         dec_prefetch_post;
  logic         dec_sample_en;
  logic [2:0]   acc_isp_clocks;
  logic [2:0]   acc_rtc_clocks;
  logic         timer_idle;

  // ----------------------------------------------------------------------
  // configuration register file
  // ----------------------------------------------------------------------

  // both channel registers share the dword at the primary offset
  assign cfg_hit = (i_cfg_addr[7:2] == ITPS_OFF_TIMING_PRI[7:2]);

  // byte-lane writes; reserved bits 11:10 never store a one
  always_comb begin
    next_timing_pri = timing_pri;
    next_timing_sec = timing_sec;
    if (i_cfg_wr && cfg_hit) begin
      if (i_cfg_be[0]) begin
        next_timing_pri[7:0] = i_cfg_wdata[7:0] & ITPS_TIMING_WMASK[7:0];
      end
      if (i_cfg_be[1]) begin
        next_timing_pri[15:8] = i_cfg_wdata[15:8] & ITPS_TIMING_WMASK[15:8];
      end
      if (i_cfg_be[2]) begin
        next_timing_sec[7:0] = i_cfg_wdata[23:16] & ITPS_TIMING_WMASK[7:0];
      end
      if (i_cfg_be[3]) begin
        next_timing_sec[15:8] = i_cfg_wdata[31:24] & ITPS_TIMING_WMASK[15:8];
      end
    end
  end

  // read data one cycle after the strobe; other dwords read as zero
  always_comb begin
    next_cfg_rvalid = i_cfg_rd;
    next_cfg_rdata  = 32'h0000_0000;
    if (i_cfg_rd && cfg_hit) begin
      next_cfg_rdata = {timing_sec, timing_pri};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      timing_pri   <= ITPS_TIMING_RESET;
      timing_sec   <= ITPS_TIMING_RESET;
      o_cfg_rdata  <= 32'h0000_0000;
      o_cfg_rvalid <= 1'b0;
    end else begin
      timing_pri   <= next_timing_pri;
      timing_sec   <= next_timing_sec;
      o_cfg_rdata  <= next_cfg_rdata;
      o_cfg_rvalid <= next_cfg_rvalid;
    end
  end

  // ----------------------------------------------------------------------
  // drive-select copies
  // ----------------------------------------------------------------------

  // the drive cannot be read back cheaply, so track every device/head write
  always_comb begin
    next_drive_sel = drive_sel;
    if (i_io_wr && !i_io_ctrl_block && (i_io_offset == ITPS_ATA_DEVHEAD_OFF)) begin
      next_drive_sel[i_io_chan] = i_io_wdata[ITPS_BIT_DRIVE_SEL];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      drive_sel <= 2'b00;
    end else begin
      drive_sel <= next_drive_sel;
    end
  end

  // ----------------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------------

  // channel register and drive copy for the access being offered
  always_comb begin
    acc_timing    = i_acc_chan ? timing_sec : timing_pri;
    acc_drive_sel = drive_sel[i_acc_chan];
    acc_data_port = !i_acc_ctrl_block && (i_acc_offset == ITPS_ATA_DATA_OFF);
    // a disabled channel is decoded elsewhere, so it never launches
    acc_launch    = i_acc_start && timer_idle && acc_timing[ITPS_BIT_DECODE_EN];
    // slave-specific counts live outside this block; these fields apply
    acc_isp_clocks = itps_isp_clocks(acc_timing[ITPS_LSB_SAMPLE_PT +: 2]);
    acc_rtc_clocks = itps_rtc_clocks(acc_timing[ITPS_LSB_RECOVERY +: 2]);
  end

  itps_path_decode u_path_decode (
    .i_timing        (acc_timing),
    .i_drive_sel     (acc_drive_sel),
    .i_data_port     (acc_data_port),
    .i_dma           (i_acc_dma),
    .o_path          (dec_path),
    .o_prefetch_post (dec_prefetch_post),
    .o_sample_en     (dec_sample_en)
  );

  // ----------------------------------------------------------------------
  // access launch and result hold
  // ----------------------------------------------------------------------

  // path and prefetch stand from launch until the next launch
  always_comb begin
    next_acc_path          = o_acc_path;
    next_acc_prefetch_post = o_acc_prefetch_post;
    if (acc_launch) begin
      next_acc_path          = dec_path;
      next_acc_prefetch_post = dec_prefetch_post;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_acc_path          <= ITPS_PATH_COMP8;
      o_acc_prefetch_post <= 1'b0;
    end else begin
      o_acc_path          <= next_acc_path;
      o_acc_prefetch_post <= next_acc_prefetch_post;
    end
  end

  itps_cycle_timer u_cycle_timer (
    .i_clk        (i_clk),
    .i_reset      (i_reset),
    .i_start      (acc_launch),
    .i_isp_clocks (acc_isp_clocks),
    .i_rtc_clocks (acc_rtc_clocks),
    .i_sample_en  (dec_sample_en),
    .i_ready      (i_ready),
    .o_strobe     (o_io_strobe),
    .o_done       (o_acc_done),
    .o_idle       (timer_idle)
  );

  // ----------------------------------------------------------------------
  // outputs straight from flops
  // ----------------------------------------------------------------------

  // all of these are register bits or timer flops, no logic after them
  assign o_acc_ready           = timer_idle;
  assign o_decode_enable       = {timing_sec[ITPS_BIT_DECODE_EN], timing_pri[ITPS_BIT_DECODE_EN]};
  assign o_slave_timing_enable = {timing_sec[ITPS_BIT_SLAVE_EN], timing_pri[ITPS_BIT_SLAVE_EN]};
  assign o_pri_sample_point    = timing_pri[ITPS_LSB_SAMPLE_PT +: 2];
  assign o_pri_recovery        = timing_pri[ITPS_LSB_RECOVERY +: 2];
  assign o_sec_sample_point    = timing_sec[ITPS_LSB_SAMPLE_PT +: 2];
  assign o_sec_recovery        = timing_sec[ITPS_LSB_RECOVERY +: 2];
  assign o_drive_select        = drive_sel;

endmodule : itps_timing_ctrl

`default_nettype wire

// File: itps_pkg.sv
/*
  Shared constants, encodings and clock-count decoders for the IDE channel
  timing control block.
  Assumes a single PCI clock domain and PCI configuration access by dword.
*/
`default_nettype none

package itps_pkg;

  // ----------------------------------------------------------------------
  // configuration space placement
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ITPS_OFF_TIMING_PRI  = 8'h40;  // bytes 40h-41h
  localparam logic [7:0]  ITPS_OFF_TIMING_SEC  = 8'h42;  // bytes 42h-43h
  localparam logic [15:0] ITPS_TIMING_RESET    = 16'h0000;
  localparam logic [15:0] ITPS_TIMING_WMASK    = 16'hF3FF; // 11:10 reserved

  // ----------------------------------------------------------------------
  // field positions of the timing control register
  // ----------------------------------------------------------------------
  localparam int ITPS_BIT_DECODE_EN   = 15;
  localparam int ITPS_BIT_SLAVE_EN    = 14;
  localparam int ITPS_LSB_SAMPLE_PT   = 12;
  localparam int ITPS_LSB_RECOVERY    = 8;
  localparam int ITPS_BIT_DMA_FAST1   = 7;
  localparam int ITPS_BIT_PREFETCH1   = 6;
  localparam int ITPS_BIT_RDY_EN1     = 5;
  localparam int ITPS_BIT_FAST_BANK1  = 4;
  localparam int ITPS_BIT_DMA_FAST0   = 3;
  localparam int ITPS_BIT_PREFETCH0   = 2;
  localparam int ITPS_BIT_RDY_EN0     = 1;
  localparam int ITPS_BIT_FAST_BANK0  = 0;

  // ----------------------------------------------------------------------
  // ata command block
  // ----------------------------------------------------------------------
  localparam logic [2:0] ITPS_ATA_DATA_OFF    = 3'h0;
  localparam logic [2:0] ITPS_ATA_DEVHEAD_OFF = 3'h6;
  localparam int         ITPS_BIT_DRIVE_SEL   = 4;

  // ----------------------------------------------------------------------
  // clock tables
  // ----------------------------------------------------------------------
  localparam logic [2:0] ITPS_ISP_CLK_00 = 3'h5;
  localparam logic [2:0] ITPS_ISP_CLK_01 = 3'h4;
  localparam logic [2:0] ITPS_ISP_CLK_10 = 3'h3;
  localparam logic [2:0] ITPS_ISP_CLK_11 = 3'h2;
  localparam logic [2:0] ITPS_RTC_CLK_00 = 3'h4;
  localparam logic [2:0] ITPS_RTC_CLK_01 = 3'h3;
  localparam logic [2:0] ITPS_RTC_CLK_10 = 3'h2;
  localparam logic [2:0] ITPS_RTC_CLK_11 = 3'h1;

  typedef enum logic [1:0] {
    ITPS_PATH_COMP8  = 2'b00,
    ITPS_PATH_COMP16 = 2'b01,
    ITPS_PATH_FAST   = 2'b10
  } itps_path_e;

  typedef enum logic [1:0] {
    ITPS_ST_IDLE    = 2'b00,
    ITPS_ST_STROBE  = 2'b01,
    ITPS_ST_RECOVER = 2'b10
  } itps_state_e;

  // sample point code to clocks from strobe assertion
  function automatic logic [2:0] itps_isp_clocks(input logic [1:0] code);
    case (code)
      2'b00:   itps_isp_clocks = ITPS_ISP_CLK_00;
      2'b01:   itps_isp_clocks = ITPS_ISP_CLK_01;
      2'b10:   itps_isp_clocks = ITPS_ISP_CLK_10;
      default: itps_isp_clocks = ITPS_ISP_CLK_11;
    endcase
  endfunction : itps_isp_clocks

  // recovery code to minimum clocks from last sample to next strobe
  function automatic logic [2:0] itps_rtc_clocks(input logic [1:0] code);
    case (code)
      2'b00:   itps_rtc_clocks = ITPS_RTC_CLK_00;
      2'b01:   itps_rtc_clocks = ITPS_RTC_CLK_01;
      2'b10:   itps_rtc_clocks = ITPS_RTC_CLK_10;
      default: itps_rtc_clocks = ITPS_RTC_CLK_11;
    endcase
  endfunction : itps_rtc_clocks

endpackage : itps_pkg

`default_nettype wire

// File: itps_path_decode.sv
/*
  Combinational path chooser: picks the timing path, prefetch/posting and
  ready sampling for one access from the channel register and drive copy.
  Assumes the caller registers the results at the start of an access.
*/
`default_nettype none

module itps_path_decode
  import itps_pkg::*;
(
  input  wire logic [15:0]          i_timing,
  input  wire logic                 i_drive_sel,
  input  wire logic                 i_data_port,
  input  wire logic                 i_dma,
  output itps_pkg::itps_path_e      o_path,
  output logic                      o_prefetch_post,
  output logic                      o_sample_en
);

  logic fast_bank;
  logic dma_only;
  logic prefetch;

  // per-drive bit selection, then path choice
  always_comb begin
    fast_bank   = i_drive_sel ? i_timing[ITPS_BIT_FAST_BANK1] : i_timing[ITPS_BIT_FAST_BANK0];
    dma_only    = i_drive_sel ? i_timing[ITPS_BIT_DMA_FAST1] : i_timing[ITPS_BIT_DMA_FAST0];
    prefetch    = i_drive_sel ? i_timing[ITPS_BIT_PREFETCH1] : i_timing[ITPS_BIT_PREFETCH0];
    o_sample_en = i_drive_sel ? i_timing[ITPS_BIT_RDY_EN1] : i_timing[ITPS_BIT_RDY_EN0];
    if (!i_data_port) begin
      o_path = ITPS_PATH_COMP8;
    end else if (i_dma) begin
      // dma takes fast timing from either the dma-only bit or the bank
      o_path = (dma_only || fast_bank) ? ITPS_PATH_FAST : ITPS_PATH_COMP16;
    end else if (fast_bank && !dma_only) begin
      o_path = ITPS_PATH_FAST;
    end else begin
      o_path = ITPS_PATH_COMP16;
    end
    // prefetch and posting only ever concern the data port
    o_prefetch_post = prefetch && i_data_port && !i_dma;
  end

endmodule : itps_path_decode

`default_nettype wire

// File: itps_cycle_timer.sv
/*
  Cycle timer for one cable access: strobe, sample ready at the sample
  point (or take it as asserted), then hold off for the recovery count.
  Assumes i_start is offered only while o_idle is high.
*/
`default_nettype none

module itps_cycle_timer
  import itps_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_start,
  input  wire logic [2:0]  i_isp_clocks,
  input  wire logic [2:0]  i_rtc_clocks,
  input  wire logic        i_sample_en,
  input  wire logic        i_ready,
  output logic             o_strobe,
  output logic             o_done,
  output logic             o_idle
);

  itps_state_e state;
  itps_state_e next_state;
  logic [2:0]  count;
  logic [2:0]  next_count;
  logic [2:0]  rtc;
  logic [2:0]  next_rtc;
  logic        sample_en;
  logic        next_sample_en;
  logic        next_strobe;
  logic        next_done;

  // ----------------------------------------------------------------------
  // strobe / sample / recovery sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_count     = count;
    next_rtc       = rtc;
    next_sample_en = sample_en;
    next_strobe    = o_strobe;
    next_done      = 1'b0;
    case (state)
      ITPS_ST_IDLE: begin
        if (i_start) begin
          // counts are latched so a config write mid-cycle cannot tear it
          next_strobe    = 1'b1;
          next_count     = i_isp_clocks - 3'h1;
          next_rtc       = i_rtc_clocks;
          next_sample_en = i_sample_en;
          next_state     = ITPS_ST_STROBE;
        end
      end
      ITPS_ST_STROBE: begin
        if (count != 3'h0) begin
          next_count = count - 3'h1;
        end else if (!sample_en || i_ready) begin
          // disabled sampling reads ready as asserted at the first point
          next_strobe = 1'b0;
          next_done   = 1'b1;
          next_count  = rtc - 3'h2;
          next_state  = (rtc == 3'h1) ? ITPS_ST_IDLE : ITPS_ST_RECOVER;
        end
      end
      ITPS_ST_RECOVER: begin
        if (count != 3'h0) begin
          next_count = count - 3'h1;
        end else begin
          next_state = ITPS_ST_IDLE;
        end
      end
      default: begin
        next_state  = ITPS_ST_IDLE;
        next_strobe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state     <= ITPS_ST_IDLE;
      count     <= 3'h0;
      rtc       <= 3'h1;
      sample_en <= 1'b0;
      o_strobe  <= 1'b0;
      o_done    <= 1'b0;
      o_idle    <= 1'b1;
    end else begin
      state     <= next_state;
      count     <= next_count;
      rtc       <= next_rtc;
      sample_en <= next_sample_en;
      o_strobe  <= next_strobe;
      o_done    <= next_done;
      o_idle    <= (next_state == ITPS_ST_IDLE);
    end
  end

endmodule : itps_cycle_timer

`default_nettype wire

// File: itps_drive_model.sv
/*
  Drive model: ready low for i_wait strobe cycles, then high.
  Assumes one strobe at a time; pull-up holds ready high.
*/
`default_nettype none

module itps_drive_model (
  input  wire logic       i_clk,
  input  wire logic       i_strobe,
  input  wire logic [3:0] i_wait,
  output logic            o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;

  // released line sits at the pull-up level
  always_ff @(posedge i_clk) begin
    cnt <= i_strobe ? cnt + {3'h0, cnt != 4'hF} : 4'h0;
  end
  assign o_ready = !i_strobe || cnt >= i_wait;
endmodule : itps_drive_model

`default_nettype wire

// File: itps_timing_ctrl_checker.sv
/*
  Checker: shadows the timing registers, watches path and cable timing.
  Assumes it is bound to itps_timing_ctrl and sees only its ports.
*/
`default_nettype none

module itps_timing_ctrl_checker
  import itps_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_cfg_wr,
  input wire logic [7:0]  i_cfg_addr,
  input wire logic [3:0]  i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic        i_acc_start,
  input wire logic        i_acc_chan,
  input wire logic        i_acc_ctrl_block,
  input wire logic [2:0]  i_acc_offset,
  input wire logic        i_acc_dma,
  input wire logic        i_ready,
  input wire logic        o_acc_ready,
  input wire logic        o_acc_done,
  input wire itps_path_e  o_acc_path,
  input wire logic        o_acc_prefetch_post,
  input wire logic        o_io_strobe,
  input wire logic [1:0]  o_decode_enable,
  input wire logic [1:0]  o_drive_select
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] WM = {ITPS_TIMING_WMASK, ITPS_TIMING_WMASK};
  logic [31:0] sh, next_sh;
  logic [15:0] tr;
  logic [3:0]  nib, scnt, next_scnt;
  logic [2:0]  isp_l, next_isp, rtc_l, next_rtc, gap, next_gap;
  logic        sen_l, next_sen, launch, data, exp_pp;
  itps_path_e  exp_path;

  // ----------------
  // helper state
  // ----------------
  // gap saturates so a long idle time never wraps
  always_comb begin
    launch = i_acc_start && o_acc_ready && o_decode_enable[i_acc_chan];
    data = !i_acc_ctrl_block && i_acc_offset == ITPS_ATA_DATA_OFF;
    tr = i_acc_chan ? sh[31:16] : sh[15:0];
    nib = o_drive_select[i_acc_chan] ? tr[7:4] : tr[3:0];
    exp_pp = nib[2] && data && !i_acc_dma;
    exp_path = !data ? ITPS_PATH_COMP8 : ((i_acc_dma ? (nib[3] || nib[0]) :
      (nib[0] && !nib[3])) ? ITPS_PATH_FAST : ITPS_PATH_COMP16);
    next_sh = sh;
    next_isp = launch ? 3'h5 - {1'b0, tr[13:12]} : isp_l;
    next_rtc = launch ? 3'h4 - {1'b0, tr[9:8]} : rtc_l;
    next_sen = launch ? nib[1] : sen_l;
    next_scnt = launch ? 4'h0 : scnt + {3'h0, o_io_strobe};
    next_gap = o_acc_done ? 3'h2 : gap + {2'h0, gap != 3'h7};
    for (int b = 0; b < 4; b++) begin
      if (i_cfg_wr && i_cfg_addr[7:2] == 6'h10 && i_cfg_be[b]) begin
        next_sh[8*b +: 8] = i_cfg_wdata[8*b +: 8] & WM[8*b +: 8];
      end
    end
  end

  // registers only
  always_ff @(posedge i_clk) begin
    sh <= i_reset ? 32'h0 : next_sh;
    isp_l <= i_reset ? 3'h0 : next_isp;
    rtc_l <= i_reset ? 3'h0 : next_rtc;
    sen_l <= i_reset ? 1'b0 : next_sen;
    scnt <= i_reset ? 4'h0 : next_scnt;
    gap <= i_reset ? 3'h7 : next_gap;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_launch;
    launch;
  endsequence
  sequence s_end;
    o_io_strobe ##1 (o_acc_done && !o_io_strobe);
  endsequence

  a_nondata_comp8: assert property (s_launch ##0 !data |=> o_acc_path == ITPS_PATH_COMP8)
    else $error("non-data path wrong");
  a_pio_path: assert property (s_launch ##0 (data && !i_acc_dma)
    |=> o_acc_path == $past(exp_path)) else $error("wrong pio data path");
  a_dma_path: assert property (s_launch ##0 (data && i_acc_dma)
    |=> o_acc_path == $past(exp_path)) else $error("wrong dma data path");
  a_prefetch_gate: assert property (s_launch |=> o_acc_prefetch_post == $past(exp_pp))
    else $error("wrong prefetch");
  a_first_sample: assert property (s_end ##0 !sen_l |-> scnt == {1'b0, isp_l})
    else $error("forced ready missed");
  a_ready_sampled: assert property (s_end ##0 sen_l |-> scnt >= {1'b0, isp_l}
    && $past(i_ready)) else $error("bad ready sample");
  a_strobe_waits: assert property (o_io_strobe && sen_l && !i_ready |=> o_io_strobe)
    else $error("strobe ended, ready low");
  a_recovery_min: assert property (s_launch |-> (o_acc_done ? rtc_l == 3'h1 : gap >= rtc_l))
    else $error("recovery too short");
endmodule : itps_timing_ctrl_checker

bind itps_timing_ctrl itps_timing_ctrl_checker u_chk (.*);

`default_nettype wire

// File: testbench.sv
/*
  Bench: config access, drive-select snoop, path choice, timing codes.
  Assumes the drive model drives ready.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import itps_pkg::*;
  logic i_clk, i_reset, i_cfg_wr, i_cfg_rd, i_io_wr, i_io_chan, i_io_ctrl_block;
  logic i_acc_start, i_acc_chan, i_acc_ctrl_block, i_acc_dma, i_ready;
  logic o_cfg_rvalid, o_acc_ready, o_acc_done, o_acc_prefetch_post, o_io_strobe;
  logic [7:0] i_cfg_addr, i_io_wdata;
  logic [3:0] i_cfg_be, drv_wait;
  logic [31:0] i_cfg_wdata, o_cfg_rdata;
  logic [2:0] i_io_offset, i_acc_offset;
  logic [1:0] o_decode_enable, o_slave_timing_enable, o_drive_select;
  logic [1:0] o_pri_sample_point, o_pri_recovery, o_sec_sample_point, o_sec_recovery;
  itps_path_e o_acc_path;
  int miscompares, samples_checked;

  itps_timing_ctrl dut (.*);
  itps_drive_model u_drv (.i_clk, .i_strobe(o_io_strobe), .i_wait(drv_wait), .o_ready(i_ready));

  // 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // inputs change 1 ns after the edge, never on it
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask : tick

  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic cfg_wr(input logic [31:0] d);
    {i_cfg_wr, i_cfg_addr, i_cfg_be, i_cfg_wdata} = {1'b1, ITPS_OFF_TIMING_PRI, 4'hF, d};
    tick();
    i_cfg_wr = 1'b0;
  endtask : cfg_wr

  // answer checked in the cycle it stands
  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] e);
    {i_cfg_rd, i_cfg_addr} = {1'b1, a};
    tick();
    i_cfg_rd = 1'b0;
    chk("cfg_rvalid", 32'h1, {31'h0, o_cfg_rvalid});
    chk("cfg_rdata", e, o_cfg_rdata);
  endtask : cfg_rd

  task automatic io_wr(input logic c, k, input logic [2:0] off, input logic [7:0] d);
    {i_io_wr, i_io_chan, i_io_ctrl_block, i_io_offset, i_io_wdata} = {1'b1, c, k, off, d};
    tick();
    i_io_wr = 1'b0;
  endtask : io_wr

  // n: strobe cycles; g: done to ready
  task automatic access(input logic c, k, input logic [2:0] off, input logic dma,
                        output int n, output int g);
    int t;
    t = 0;
    while (o_acc_ready !== 1'b1 && t < 40) begin
      tick();
      t++;
    end
    {i_acc_start, i_acc_chan, i_acc_ctrl_block, i_acc_offset, i_acc_dma} = {1'b1, c, k, off, dma};
    tick();
    i_acc_start = 1'b0;
    n = 0;
    while (o_acc_done !== 1'b1 && t < 40) begin
      n += (o_io_strobe === 1'b1);
      tick();
      t++;
    end
    g = 1;
    while (o_acc_ready !== 1'b1 && t < 40) begin
      tick();
      g++;
      t++;
    end
    if (t >= 40) begin
      miscompares++;
      end_of_test();
    end
  endtask : access

  // reset values, reserved bits, unmapped dword, decode off
  task automatic t_regs;
    i_acc_start = 1'b1;
    tick();
    i_acc_start = 1'b0;
    tick();
    chk("strobe_decode_off", 32'h0, {31'h0, o_io_strobe});
    cfg_rd(ITPS_OFF_TIMING_PRI, {ITPS_TIMING_RESET, ITPS_TIMING_RESET});
    cfg_wr(32'hFFFF_FFFF);
    cfg_rd(ITPS_OFF_TIMING_PRI, {ITPS_TIMING_WMASK, ITPS_TIMING_WMASK});
    cfg_rd(8'h44, 32'h0);
    chk("enables", 32'hF, {28'h0, o_slave_timing_enable, o_decode_enable});
    cfg_wr(32'h0);
    $display("test regs done");
  endtask : t_regs

  // only command-block device/head writes move it
  task automatic t_dsel;
    io_wr(1'b1, 1'b0, ITPS_ATA_DEVHEAD_OFF, 8'h10);
    chk("dsel_set", 32'h2, {30'h0, o_drive_select});
    io_wr(1'b1, 1'b0, 3'h5, 8'h00);
    io_wr(1'b1, 1'b1, ITPS_ATA_DEVHEAD_OFF, 8'h00);
    chk("dsel_keep", 32'h2, {30'h0, o_drive_select});
    io_wr(1'b1, 1'b0, ITPS_ATA_DEVHEAD_OFF, 8'hEF);
    chk("dsel_clear", 32'h0, {30'h0, o_drive_select});
    $display("test dsel done");
  endtask : t_dsel

  // other drive and channel get inverted bits
  task automatic t_path;
    logic [15:0] v;
    logic [3:0] nib;
    logic [1:0] k;
    itps_path_e ep;
    int n, g;
    drv_wait = 4'hF;
    for (int i = 0; i < 128; i++) begin
      k = i[1:0];
      nib = {i[4], i[3], 1'b0, i[2]};
      v = 16'hB300 | ({12'h0, nib} << (4 * i[5])) | ({12'h0, ~nib & 4'hD} << (4 * !i[5]));
      io_wr(i[6], 1'b0, ITPS_ATA_DEVHEAD_OFF, {3'h0, i[5], 4'h0});
      cfg_wr(i[6] ? {v, 16'h8000 | (~v & 16'h00DD)} : {16'h8000 | (~v & 16'h00DD), v});
      access(i[6], k == 2'h3, k == 2'h2 ? 3'h7 : 3'h0, k == 2'h1, n, g);
      if (k > 2'h1) ep = ITPS_PATH_COMP8;
      else if (k == 2'h1 ? (nib[3] | nib[0]) : (nib[0] & !nib[3])) ep = ITPS_PATH_FAST;
      else ep = ITPS_PATH_COMP16;
      chk("path", {30'h0, ep}, {30'h0, o_acc_path});
      chk("prefetch", {31'h0, nib[2] & k == 2'h0}, {31'h0, o_acc_prefetch_post});
      chk("strobe_len", 32'h2, 32'(n));
      chk("recovery", 32'h1, 32'(g));
    end
    $display("test path done");
  endtask : t_path

  // all timing codes, sampling on and off
  task automatic t_timing;
    logic [15:0] v;
    logic [1:0] code;
    int n, g, en;
    for (int i = 0; i < 32; i++) begin
      code = i[1:0];
      drv_wait = 4'h3 + {2'h0, code};
      v = {2'b10, code, 2'b00, code, 8'h00} | (16'h0002 << (4 * (i[3] ^ !i[2])));
      io_wr(i[4], 1'b0, ITPS_ATA_DEVHEAD_OFF, {3'h0, i[3], 4'h0});
      cfg_wr(i[4] ? {v, 16'h0} : {16'h0, v});
      access(i[4], 1'b0, 3'h0, 1'b0, n, g);
      en = (i[2] && 5 - code < 4 + code) ? 4 + code : 5 - code;
      chk("strobe_len", 32'(en), 32'(n));
      chk("recovery", 32'(4 - code), 32'(g));
      chk("fields", i[4] ? {24'h0, code, code, 4'h0} : {28'h0, code, code}, {24'h0,
          o_sec_sample_point, o_sec_recovery, o_pri_sample_point, o_pri_recovery});
    end
    $display("test timing done");
  endtask : t_timing

  initial begin
    {i_cfg_wr, i_cfg_rd, i_io_wr, i_io_chan, i_io_ctrl_block, i_acc_start} = '0;
    {i_acc_chan, i_acc_ctrl_block, i_acc_dma, i_cfg_addr, i_io_wdata, i_cfg_be} = '0;
    {drv_wait, i_cfg_wdata, i_io_offset, i_acc_offset} = '0;
    i_reset = 1'b1;
    repeat (10) tick();
    i_reset = 1'b0;
    t_regs();
    t_dsel();
    t_path();
    t_timing();
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
